// File: design/cfi_top.sv
/*
  Event enable and status flag registers for sixteen CAN message FIFOs,
  with a sticky summary status, mask and one level interrupt.
  Assumes the FIFO occupancy logic supplies live full/half/empty levels,
  a direction level and a one-cycle overflow pulse per FIFO, all
  synchronous to core_clk_i.
*/
// Chosen here: the address map and the strobed register port.
`include "cfi_regs.svh"

module cfi_top
  import cfi_pkg::*;
#(
  parameter int NUM_FIFO = `CFI_NUM_FIFO
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [`CFI_ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic [NUM_FIFO-1:0] fifo_direction_transmit_i,
  input wire logic [NUM_FIFO-1:0] fifo_full_i,
  input wire logic [NUM_FIFO-1:0] fifo_half_i,
  input wire logic [NUM_FIFO-1:0] fifo_empty_i,
  input wire logic [NUM_FIFO-1:0] fifo_overflow_i,
  output logic [NUM_FIFO-1:0] fifo_irq_o,
  output logic irq_o
);

  localparam int IDX_W = (NUM_FIFO > 1) ? $clog2(NUM_FIFO) : 1;

  function automatic logic fifo_hit(input logic [`CFI_ADDR_W-1:0] addr);
    logic [`CFI_ADDR_W-1:0] off;
    off = addr - `CFI_FIFO_BASE;
    return (off[1:0] == 2'h0) && ({2'h0, off[`CFI_ADDR_W-1:2]} < `CFI_ADDR_W'(NUM_FIFO));
  endfunction

  function automatic logic [IDX_W-1:0] fifo_idx(input logic [`CFI_ADDR_W-1:0] addr);
    logic [`CFI_ADDR_W-1:0] off;
    off = addr - `CFI_FIFO_BASE;
    return off[2 +: IDX_W];
  endfunction

  // direction gated flags, overflow not gated
  // flags other than overflow are pure functions of the live fifo state; overflow comes latched from ovf_ff
  function automatic cfi_ev_t live_flags(input logic dir, input logic full,
                                         input logic half, input logic empty,
                                         input logic ovf);
    cfi_ev_t f;
    f[6] = dir & ~full;
    f[5] = dir & half;
    f[4] = dir & empty;
    f[3] = ovf;
    f[2] = ~dir & full;
    f[1] = ~dir & half;
    f[0] = ~dir & ~empty;
    return f;
  endfunction

  function automatic cfi_word_t pack_word(input cfi_ev_t en, input cfi_ev_t fl);
    cfi_word_t w;
    w = '0;
    w[`CFI_FIFO_DIRECTION_TRANSMIT_HI:`CFI_FIFO_DIRECTION_TRANSMIT_LO] = en[6:4];
    w[`CFI_RXEN_HI:`CFI_RXEN_LO] = en[3:0];
    w[`CFI_TXFL_HI:`CFI_TXFL_LO] = fl[6:4];
    w[`CFI_RXFL_HI:`CFI_RXFL_LO] = fl[3:0];
    return w;
  endfunction

  cfi_ev_t en_ff [NUM_FIFO];
  logic [NUM_FIFO-1:0] ovf_ff;
  cfi_ev_t flags [NUM_FIFO];
  logic [NUM_FIFO-1:0] req_now;
  logic [NUM_FIFO-1:0] stat_ff;
  logic [NUM_FIFO-1:0] nxt_stat;
  logic [NUM_FIFO-1:0] mask_ff;
  logic [NUM_FIFO-1:0] nxt_mask;
  logic [NUM_FIFO-1:0] fifo_irq_ff;
  logic irq_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic acc_hit;
  logic [IDX_W-1:0] acc_idx;
  logic wr_fifo;
  logic wr_stat;
  logic wr_mask;

  assign acc_hit = fifo_hit(reg_addr_i);
  assign acc_idx = fifo_idx(reg_addr_i);
  assign wr_fifo = reg_wr_i && acc_hit;
  assign wr_stat = reg_wr_i && (reg_addr_i == `CFI_STAT_ADDR);
  assign wr_mask = reg_wr_i && (reg_addr_i == `CFI_MASK_ADDR);

  always_comb begin
    for (int i = 0; i < NUM_FIFO; i++) begin
      flags[i] = live_flags(fifo_direction_transmit_i[i], fifo_full_i[i],
                            fifo_half_i[i], fifo_empty_i[i], ovf_ff[i]);
      req_now[i] = |(en_ff[i] & flags[i]);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < NUM_FIFO; i++) begin
        en_ff[i] <= `CFI_EN_RST;
      end
    end else if (wr_fifo) begin
      en_ff[acc_idx] <= {reg_wdata_i[`CFI_FIFO_DIRECTION_TRANSMIT_HI:`CFI_FIFO_DIRECTION_TRANSMIT_LO],
                         reg_wdata_i[`CFI_RXEN_HI:`CFI_RXEN_LO]};
    end
  end

  // overflow is the one writable flag: software clears it by writing zero;
  // a new overflow in the same cycle wins so the event is not lost
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      ovf_ff <= '0;
    end else begin
      for (int i = 0; i < NUM_FIFO; i++) begin
        if (fifo_overflow_i[i]) begin
          ovf_ff[i] <= 1'b1;
        end else if (wr_fifo && (acc_idx == IDX_W'(i)) && !reg_wdata_i[`CFI_RXOV_FL_BIT]) begin
          ovf_ff[i] <= 1'b0;
        end
      end
    end
  end

  // sticky summary: set while a fifo requests, write one to clear, set wins
  always_comb begin
    nxt_stat = req_now | (stat_ff & ~(wr_stat ? reg_wdata_i[NUM_FIFO-1:0] : '0));
    nxt_mask = wr_mask ? reg_wdata_i[NUM_FIFO-1:0] : mask_ff;
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      stat_ff <= NUM_FIFO'(`CFI_STAT_RST);
      mask_ff <= NUM_FIFO'(`CFI_STAT_RST);
      irq_ff <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      // computed from next values so irq_o tracks stat/mask with no lag
      irq_ff <= |(nxt_stat & nxt_mask);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      fifo_irq_ff <= '0;
    end else begin
      fifo_irq_ff <= req_now;
    end
  end

  // unmapped and reserved read as zero
  always_comb begin
    nxt_rdata = '0;
    if (reg_rd_i) begin
      if (acc_hit) begin
        nxt_rdata = pack_word(en_ff[acc_idx], flags[acc_idx]);
      end else if (reg_addr_i == `CFI_STAT_ADDR) begin
        nxt_rdata[NUM_FIFO-1:0] = stat_ff;
      end else if (reg_addr_i == `CFI_MASK_ADDR) begin
        nxt_rdata[NUM_FIFO-1:0] = mask_ff;
      end
    end
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign fifo_irq_o = fifo_irq_ff;
  assign irq_o = irq_ff;

  unmapped_read_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    reg_rd_i && !acc_hit && (reg_addr_i != `CFI_STAT_ADDR)
      && (reg_addr_i != `CFI_MASK_ADDR) |=> reg_rdata_o == 32'h0000_0000)
    else $error("unmapped read returned nonzero data");

  reserved_bits_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    reg_rd_i && acc_hit |=> (reg_rdata_o[31:27] == 5'h00) && (reg_rdata_o[23:20] == 4'h0)
      && (reg_rdata_o[15:11] == 5'h00) && (reg_rdata_o[7:4] == 4'h0))
    else $error("reserved bits of a fifo register read nonzero");

  txnf_enable_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    reg_wr_i && acc_hit ##1 reg_rd_i && (reg_addr_i == $past(reg_addr_i))
      |=> reg_rdata_o[`CFI_TXNF_EN_BIT] == $past(reg_wdata_i[`CFI_TXNF_EN_BIT], 2))
    else $error("tx not-full enable did not read back as written");

  tx_enables_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    reg_wr_i && acc_hit ##1 reg_rd_i && (reg_addr_i == $past(reg_addr_i))
      |=> reg_rdata_o[25:24] == $past(reg_wdata_i[25:24], 2))
    else $error("tx half/empty enables did not read back as written");

  rxov_enable_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    reg_wr_i && acc_hit ##1 reg_rd_i && (reg_addr_i == $past(reg_addr_i))
      |=> reg_rdata_o[`CFI_RXOV_EN_BIT] == $past(reg_wdata_i[`CFI_RXOV_EN_BIT], 2))
    else $error("rx overflow enable did not read back as written");

  rx_enables_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    reg_wr_i && acc_hit ##1 reg_rd_i && (reg_addr_i == $past(reg_addr_i))
      |=> reg_rdata_o[18:16] == $past(reg_wdata_i[18:16], 2))
    else $error("rx full/half/not-empty enables did not read back");

  txnf_flag_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    reg_rd_i && acc_hit && fifo_direction_transmit_i[acc_idx]
      |=> reg_rdata_o[`CFI_TXNF_FL_BIT] == !$past(fifo_full_i[acc_idx]))
    else $error("tx not-full flag does not match fifo space");

  rx_txnf_zero_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    reg_rd_i && acc_hit && !fifo_direction_transmit_i[acc_idx]
      |=> !reg_rdata_o[`CFI_TXNF_FL_BIT])
    else $error("tx not-full flag set in receive mode");

  flag_live_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    reg_wr_i && acc_hit && reg_wdata_i[`CFI_TXNF_FL_BIT]
      ##1 reg_rd_i && (reg_addr_i == $past(reg_addr_i))
      && fifo_direction_transmit_i[acc_idx] && fifo_full_i[acc_idx]
      |=> !reg_rdata_o[`CFI_TXNF_FL_BIT])
    else $error("write to read-only flag was latched");

  fifo_req_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    en_ff[0][6] && fifo_direction_transmit_i[0] && !fifo_full_i[0] |=> fifo_irq_o[0])
    else $error("enabled tx not-full event gave no request");

  no_req_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    (en_ff[0] == 7'h00) |=> !fifo_irq_o[0])
    else $error("fifo request raised with all enables clear");

  irq_level_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    ##1 irq_o == |(stat_ff & mask_ff))
    else $error("interrupt output disagrees with masked status");

  stat_sticky_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    stat_ff[0] && !(wr_stat && reg_wdata_i[0]) |=> stat_ff[0])
    else $error("status bit dropped without a clearing write");

  stat_clear_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    wr_stat && reg_wdata_i[0] && !req_now[0] |=> !stat_ff[0])
    else $error("status bit survived a clearing write with no request");

  rdata_idle_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    !reg_rd_i |=> reg_rdata_o == 32'h0000_0000)
    else $error("read data nonzero without a read strobe");

  ovf_set_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    (fifo_overflow_i != '0) |=> (ovf_ff & $past(fifo_overflow_i)) == $past(fifo_overflow_i))
    else $error("overflow event did not set its flag");

  ovf_clear_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    wr_fifo && (acc_idx == '0) && !reg_wdata_i[`CFI_RXOV_FL_BIT] && !fifo_overflow_i[0]
      |=> !ovf_ff[0])
    else $error("overflow flag not cleared by a zero write");

  rx_in_tx_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    reg_rd_i && acc_hit && fifo_direction_transmit_i[acc_idx]
      |=> reg_rdata_o[`CFI_RXFL_HI-1:`CFI_RXFL_LO] == 3'h0)
    else $error("receive level flags set in transmit mode");

  reset_clear_a: assert property (
    @(posedge core_clk_i) disable iff (!resetn_i)
    $rose(resetn_i) |-> (en_ff[0] == `CFI_EN_RST) && !irq_o && (reg_rdata_o == 32'h0))
    else $error("state not cleared after reset release");

endmodule // cfi_top

// File: pkg/cfi_regs.svh
/*
  Register map constants for the CAN FIFO event enable/flag block.
  Assumes a plain word-addressed register port with byte addresses.
*/
`ifndef CFI_REGS_SVH
`define CFI_REGS_SVH

`define CFI_NUM_FIFO 16
`define CFI_ADDR_W 8
`define CFI_FIFO_BASE 8'h00
`define CFI_STAT_ADDR 8'h40
`define CFI_MASK_ADDR 8'h44

// enable fields
`define CFI_TXNF_EN_BIT 26
`define CFI_FIFO_DIRECTION_TRANSMIT_HI 26
`define CFI_FIFO_DIRECTION_TRANSMIT_LO 24
`define CFI_RXOV_EN_BIT 19
`define CFI_RXEN_HI 19
`define CFI_RXEN_LO 16
// flag fields
`define CFI_TXNF_FL_BIT 10
`define CFI_TXFL_HI 10
`define CFI_TXFL_LO 8
`define CFI_RXOV_FL_BIT 3
`define CFI_RXFL_HI 3
`define CFI_RXFL_LO 0

`define CFI_EN_RST 7'h00
`define CFI_STAT_RST 16'h0000

`endif

// File: pkg/cfi_pkg.sv
/*
  Types shared by the CAN FIFO event block.
  Assumes cfi_regs.svh supplies the bit positions.
*/
package cfi_pkg;
  // seven event bits: [6] tx not full, [5] tx half, [4] tx empty,
  // [3] rx overflow, [2] rx full, [1] rx half, [0] rx not empty
  typedef logic [6:0] cfi_ev_t;
  typedef logic [31:0] cfi_word_t;
endpackage

// File: test/cfi_fifo_model.sv
/*
  Behavioural occupancy model for sixteen CAN message FIFOs.
  Assumes push and pop strobes driven by the bench on core_clk_i.
*/
module cfi_fifo_model #(
  parameter int DEPTH = 4
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [15:0] push_i,
  input wire logic [15:0] pop_i,
  output logic [15:0] full_o,
  output logic [15:0] half_o,
  output logic [15:0] empty_o,
  output logic [15:0] overflow_o
);
  int cnt_ff [16];

  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < 16; i++) begin
      if (!resetn_i) begin
        cnt_ff[i] <= 0;
        overflow_o[i] <= 1'b0;
      end else begin
        // push into a full fifo is lost, one-cycle overflow pulse
        overflow_o[i] <= push_i[i] && (cnt_ff[i] == DEPTH);
        if (push_i[i] && cnt_ff[i] < DEPTH) begin
          cnt_ff[i] <= cnt_ff[i] + 1;
        end else if (pop_i[i] && cnt_ff[i] > 0) begin
          cnt_ff[i] <= cnt_ff[i] - 1;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 16; i++) begin
      full_o[i] = cnt_ff[i] == DEPTH;
      half_o[i] = cnt_ff[i] >= DEPTH / 2;
      empty_o[i] = cnt_ff[i] == 0;
    end
  end
endmodule // cfi_fifo_model

// File: test/cfi_top_tb_top.sv
/*
  Self-checking bench for the FIFO event enable and flag registers.
  Assumes the occupancy model of depth 4 feeds the fifo level inputs.
*/
`include "cfi_regs.svh"

module cfi_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic d; int k; logic [31:0] exp;} cfi_row_t;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [15:0] dir = 16'h0;
  logic [15:0] full, half, empty, ovf, fifo_irq, push = 16'h0, pop = 16'h0;
  logic irq;
  int error_cnt = 0;
  int checked = 0;
  int cycles = 0;
  cfi_row_t rows [6] = '{'{1'b1, 0, 32'h500}, '{1'b1, 2, 32'h600}, '{1'b1, 4, 32'h200},
                         '{1'b0, 0, 32'h0}, '{1'b0, 2, 32'h3}, '{1'b0, 4, 32'h7}};
  logic [31:0] en_tab [3] = '{32'h04000000, 32'h01000000, 32'h02000000};

  cfi_top dut (.core_clk_i(clk), .resetn_i(resetn), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .fifo_direction_transmit_i(dir),
    .fifo_full_i(full), .fifo_half_i(half), .fifo_empty_i(empty), .fifo_overflow_i(ovf),
    .fifo_irq_o(fifo_irq), .irq_o(irq));
  cfi_fifo_model #(.DEPTH(4)) model (.core_clk_i(clk), .resetn_i(resetn), .push_i(push),
    .pop_i(pop), .full_o(full), .half_o(half), .empty_o(empty), .overflow_o(ovf));

  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    // limit far above the few hundred cycles the tests need
    if (cycles == 20000) begin
      error_cnt++;
      $display("[ERR] %0t: run hung", $time);
      stop_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand one cycle only, then fall to zero
  task automatic rd_tail(input logic [7:0] a, input logic [31:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
    @(posedge clk);
    #1;
    check(rdata, 32'h0);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd_tail(a, exp);
  endtask

  // write then read with no gap, as the bus allows
  task automatic wr_rd_chk(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd_tail(a, exp);
  endtask

  task automatic set_fill(input int n, input int k);
    repeat (4) begin
      @(posedge clk);
      pop[n] <= 1'b1;
    end
    @(posedge clk);
    pop[n] <= 1'b0;
    repeat (k) begin
      @(posedge clk);
      push[n] <= 1'b1;
    end
    @(posedge clk);
    push[n] <= 1'b0;
  endtask

  task automatic irq_chk(input logic [31:0] exp);
    repeat (3) @(posedge clk);
    #1;
    check({15'h0, irq, fifo_irq}, exp);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    #1;
    check(rdata | {15'h0, irq, fifo_irq}, 32'h0);
    @(posedge clk);
    resetn <= 1'b1;
    rd_chk(`CFI_STAT_ADDR, 32'h0);
    rd_chk(`CFI_MASK_ADDR, 32'h0);
    for (int i = 0; i < 16; i++) begin
      wr_rd_chk(8'(4 * i), {5'h0, 3'(~i), 4'h0, 4'(i), 16'h0},
                {5'h0, 3'(~i), 4'h0, 4'(i), 16'h0});
      wr_reg(8'(4 * i), 32'h0);
    end
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      dir[i] <= rows[i].d;
      set_fill(i, rows[i].k);
      rd_chk(8'(4 * i), rows[i].exp);
    end
    wr_rd_chk(8'h08, 32'h00000700, 32'h00000200);
    @(posedge clk);
    push[5] <= 1'b1;
    @(posedge clk);
    push[5] <= 1'b0;
    rd_chk(8'h14, 32'h0000000f);
    wr_reg(8'h14, 32'h00080008);
    rd_chk(8'h14, 32'h0008000f);
    irq_chk(32'h20);
    wr_reg(8'h14, 32'h00080000);
    rd_chk(8'h14, 32'h00080007);
    irq_chk(32'h0);
    rd_chk(`CFI_STAT_ADDR, 32'h20);
    wr_reg(`CFI_STAT_ADDR, 32'h20);
    rd_chk(`CFI_STAT_ADDR, 32'h0);
    set_fill(0, 0);
    wr_reg(8'h00, 32'hffffffff);
    rd_chk(8'h00, 32'h070f0500);
    irq_chk(32'h1);
    wr_reg(`CFI_MASK_ADDR, 32'h1);
    wr_reg(`CFI_STAT_ADDR, 32'h1);
    irq_chk(32'h10001);
    for (int i = 0; i < 3; i++) begin
      wr_reg(8'h00, en_tab[i]);
      irq_chk({31'h0, i < 2} | 32'h10000);
    end
    wr_reg(`CFI_STAT_ADDR, 32'h1);
    irq_chk(32'h0);
    wr_reg(8'h80, 32'hffffffff);
    rd_chk(8'h80, 32'h0);
    wr_reg(`CFI_MASK_ADDR, 32'h1);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    #1;
    check(rdata | {15'h0, irq, fifo_irq}, 32'h0);
    rd_chk(8'h00, 32'h00000500);
    rd_chk(`CFI_MASK_ADDR, 32'h0);
    rd_chk(`CFI_STAT_ADDR, 32'h0);
    stop_test();
  end
endmodule // cfi_top_tb_top
